// [ddrgs_dly_if.sv]
// Purpose: Margin control bundle between the strobe unit and one delay line.
// Assumes: All signals are on the sampling clock.
// Notes:   The line reports its live code back to the controller.
`timescale 1ns/100ps
interface ddrgs_dly_if;
	logic        load_n;
	logic        step;
	logic        dir;
	logic [8:0]  cal;
	logic [8:0]  code;
	modport ctrl (output load_n, output step, output dir, output cal, input code);
	modport line (input load_n, input step, input dir, input cal, output code);
endinterface : ddrgs_dly_if

// [ddrgs_dly_line.sv]
// Purpose: Slave delay line with calibrated code and one-tap margin moves.
// Assumes: Step is a level from core logic; each rising edge is one move unless a load or a code end blocks it.
// Notes:   Tap resolution is one sampling clock; a fixed quarter period leads.
`timescale 1ns/100ps
module ddrgs_dly_line import ddrgs_pkg::*; (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  din,
	ddrgs_dly_if.line  c,
	output logic       dout
);
	logic [CODE_W-1:0]  code_q;
	logic               step_q;
	logic [DLY_LEN-1:0] sh_q;
	logic [4:0]         idx;

	assign c.code = code_q;
	assign idx    = 5'(QUARTER_CYC) + {1'b0, code_q[3:0]};

	always_ff @(posedge clk) begin
		step_q <= rst ? 1'b0 : c.step;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			code_q <= CODE_RST;
		end else if (!c.load_n) begin
			code_q <= c.cal;
		end else if (c.step && !step_q) begin
			if (c.dir && code_q != CODE_MAX) begin
				code_q <= code_q + 9'h001;
			end else if (!c.dir && code_q != CODE_RST) begin
				code_q <= code_q - 9'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sh_q <= '0;
			dout <= 1'b0;
		end else begin
			sh_q <= {sh_q[DLY_LEN-2:0], din};
			dout <= sh_q[idx];
		end
	end

	a_step_up: assert property (@(posedge clk) disable iff (rst)
		c.load_n && c.step && !step_q && c.dir && code_q != CODE_MAX
		|=> code_q == $past(code_q) + 9'h001)
		else $error("delay line did not step up by one tap");
	a_load_cal: assert property (@(posedge clk) disable iff (rst)
		!c.load_n |=> code_q == $past(c.cal))
		else $error("delay line did not restore the calibrated code");
endmodule : ddrgs_dly_line

// [ddrgs_link_model.sv]
// Purpose: Far-side model: source-synchronous sender of edge clock, data and strobe.
// Assumes: Edge clock runs free at 400 ns; data is centre-aligned.
// Notes:   Strobe echoes the edge clock only while enabled, as a memory read would.
`timescale 1ns/100ps
module ddrgs_link_model import ddrgs_pkg::*; (
	input  wire logic       strobe_en,
	input  wire logic [9:0] pat,
	input  wire logic [3:0] bits,
	output logic            edge_clk,
	output logic            data,
	output logic            strobe
);
	int idx;
	initial begin
		edge_clk = 1'b0;
		data = 1'b0;
		strobe = 1'b0;
		idx = 0;
		// The odd offset keeps link edges clear of the sampling clock edges.
		#37;
		forever begin
			#(EDGE_PERIOD_NS / 4);
			data = pat[int'(bits) - 1 - idx];
			idx = (idx + 1 >= int'(bits)) ? 0 : idx + 1;
			#(EDGE_PERIOD_NS / 4);
			edge_clk = ~edge_clk;
			strobe = strobe_en & edge_clk;
		end
	end
endmodule : ddrgs_link_model

// [ddrgs_pkg.sv]
// Purpose: Shared constants, types and helpers for the DDR I/O gearing block.
// Assumes: One 20 MHz clock samples every fast signal; the bench edge clock is 400 ns.
// Notes:   Delay lines are modelled as tapped shift registers on the sampling clock.
// Functional notes
// - Input path delivers 2/4/7/8/10-bit words.
// - Core alignment request slips the word boundary.
// - DDR edge serializer: 1x, 2x, x4, x5, 7:1.
// - Other edges offer single-rate output only.
// - SDR registers one bit; geared modes serialize words.
// - Provide read strobe, strobe write, data write clocks.
// - SDR tristate uses one flip-flop.
// - DDR tristate takes two bits, both clocks.
// - Strobe groups of sixteen, two strobe pins.
// - Read strobe passes calibrated slave delay line.
// - Write delay line plus separate leveling line.
// - Separate read/write margin controls, 9-bit code.
// - Generate 3-bit FIFO read and write pointers.
// - Core drives read request and pulse select.
// - Valid flag, burst detect, read/write counts.
// - Core reset clears input, output, tristate registers.
// - Three input stages: sample, align, transfer.
// - One FIFO control per group feeds all cells.
package ddrgs_pkg;
	localparam int CLK_PERIOD_NS  = 50;
	localparam int EDGE_PERIOD_NS = 400;
	localparam int QUARTER_CYC    = (EDGE_PERIOD_NS / 4) / CLK_PERIOD_NS;
	localparam int RX_W           = 10;
	localparam int CODE_W         = 9;
	localparam int PTR_W          = 3;
	localparam int TAPS           = 16;
	localparam int DLY_LEN        = TAPS + QUARTER_CYC;
	localparam int GROUP_PINS     = 16;
	localparam int GROUP_STROBES  = 2;
	localparam logic [CODE_W-1:0] CODE_RST = 9'h000;
	localparam logic [CODE_W-1:0] CODE_MAX = 9'h1FF;
	localparam logic [PTR_W-1:0]  PTR_RST  = 3'h0;
	localparam logic [PTR_W-1:0]  PTR_LAST = 3'h7;

	typedef enum logic [5:0] {
		GEAR_SDR = 6'h01,
		GEAR_X1  = 6'h02,
		GEAR_X2  = 6'h04,
		GEAR_X71 = 6'h08,
		GEAR_X4  = 6'h10,
		GEAR_X5  = 6'h20
	} ddrgs_gear_t;

	function automatic ddrgs_gear_t ddrgs_decode(input logic [2:0] sel);
		case (sel)
			3'h0: ddrgs_decode = GEAR_SDR;
			3'h2: ddrgs_decode = GEAR_X2;
			3'h3: ddrgs_decode = GEAR_X71;
			3'h4: ddrgs_decode = GEAR_X4;
			3'h5: ddrgs_decode = GEAR_X5;
			default: ddrgs_decode = GEAR_X1;
		endcase
	endfunction : ddrgs_decode

	function automatic logic [3:0] ddrgs_bits(input ddrgs_gear_t g);
		case (g)
			GEAR_SDR: ddrgs_bits = 4'h1;
			GEAR_X2:  ddrgs_bits = 4'h4;
			GEAR_X71: ddrgs_bits = 4'h7;
			GEAR_X4:  ddrgs_bits = 4'h8;
			GEAR_X5:  ddrgs_bits = 4'hA;
			default:  ddrgs_bits = 4'h2;
		endcase
	endfunction : ddrgs_bits

	function automatic logic [RX_W-1:0] ddrgs_mask(input logic [3:0] bits);
		logic [RX_W:0] one;
		one = 11'h001 << bits;
		ddrgs_mask = RX_W'(one - 11'h001);
	endfunction : ddrgs_mask

	function automatic logic [3:0] ddrgs_burst(input logic [1:0] req);
		case (req)
			2'h1: ddrgs_burst = 4'h2;
			2'h2: ddrgs_burst = 4'h4;
			2'h3: ddrgs_burst = 4'h8;
			default: ddrgs_burst = 4'h0;
		endcase
	endfunction : ddrgs_burst
endpackage : ddrgs_pkg

// [ddrgs_rx_gear.sv]
// Purpose: Input deserializer with word alignment and slow-clock transfer.
// Assumes: bit_en marks each used fast edge, both in DDR gears and rising only in SDR; word_en is the slow clock enable.
// Notes:   An alignment request slips the boundary by exactly one bit.
`timescale 1ns/100ps
module ddrgs_rx_gear import ddrgs_pkg::*; (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            bit_en,
	input  wire logic            din,
	input  wire logic            align,
	input  wire logic            word_en,
	input  wire logic [3:0]      bits,
	output logic      [RX_W-1:0] word
);
	logic [RX_W-1:0] shift_q;
	logic [RX_W-1:0] shift_d;
	logic [RX_W-1:0] upd_q;
	logic [3:0]      cnt_q;
	logic            pend_q;
	logic            last;
	logic [3:0]      bits_q;

	assign shift_d = {shift_q[RX_W-2:0], din};
	assign last    = cnt_q >= bits - 4'h1;

	always_ff @(posedge clk) begin
		bits_q <= rst ? 4'h0 : bits;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shift_q <= '0;
		end else if (bit_en) begin
			shift_q <= shift_d;
		end
	end

	// A request landing on a bit edge stays pending so it is never lost.
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q <= 1'b0;
		end else if (align) begin
			pend_q <= 1'b1;
		end else if (bit_en) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 4'h0;
		end else if (bit_en && !pend_q) begin
			cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
		end
	end

	// A ratio change clears the last completed word in upd_q, so no stale upper bits reach the core.
	always_ff @(posedge clk) begin
		if (rst) begin
			upd_q <= '0;
		end else if (bits != bits_q) begin
			upd_q <= '0;
		end else if (bit_en && !pend_q && last) begin
			upd_q <= shift_d & ddrgs_mask(bits);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			word <= '0;
		end else if (word_en) begin
			word <= upd_q;
		end
	end

	a_align_slip: assert property (@(posedge clk) disable iff (rst)
		pend_q && bit_en && !align |=> cnt_q == $past(cnt_q) && !pend_q)
		else $error("alignment did not hold the bit counter");
	a_rx_width: assert property (@(posedge clk) disable iff (rst)
		(upd_q & ~ddrgs_mask(bits)) == '0 || $changed(bits))
		else $error("aligned word wider than the gearing ratio");
	c_align: cover property (@(posedge clk) disable iff (rst) pend_q && bit_en);
endmodule : ddrgs_rx_gear

// [ddrgs_top.sv]
// Purpose: Per-pin gearing, tristate registering and strobe delay control.
// Assumes: Edge clock, strobe and data pin are sampled on CLOCK.
// Notes:   Slow clock is an enable derived from edge-clock bit counting.
`timescale 1ns/100ps
module ddrgs_top import ddrgs_pkg::*; (
	input  wire logic              CLOCK,
	input  wire logic              NRST,
	input  wire logic              IO_RST,
	input  wire logic              EDGE_IS_DDR,
	input  wire logic [2:0]        GEAR_SEL,
	input  wire logic              FAST_EDGE_CLK,
	input  wire logic              STROBE_IN,
	input  wire logic              DATA_PIN,
	input  wire logic              WORD_ALIGN_REQ,
	output logic      [RX_W-1:0]   RX_WORD,
	input  wire logic              TX_BIT,
	input  wire logic [RX_W-1:0]   TX_WORD,
	output logic                   TX_PIN,
	input  wire logic              TRISTATE_DDR,
	input  wire logic [1:0]        TRISTATE_CTRL_IN,
	output logic                   TRISTATE_CTRL_OUT,
	input  wire logic [1:0]        READ_REQ,
	input  wire logic [2:0]        READ_PULSE_SEL,
	input  wire logic              READ_DELAY_LOAD_N,
	input  wire logic              READ_DELAY_STEP,
	input  wire logic              READ_DELAY_DIR,
	input  wire logic              WRITE_DELAY_LOAD_N,
	input  wire logic              WRITE_DELAY_STEP,
	input  wire logic              WRITE_DELAY_DIR,
	input  wire logic              WRITE_LEVEL_EN,
	input  wire logic              WRITE_LEVEL_LOAD_N,
	input  wire logic              WRITE_LEVEL_STEP,
	input  wire logic              WRITE_LEVEL_DIR,
	input  wire logic [CODE_W-1:0] DELAY_CODE_IN,
	output logic      [CODE_W-1:0] DELAY_CODE_OUT,
	output logic                   READ_CAPTURE_STROBE,
	output logic                   STROBE_WRITE_CLK,
	output logic                   DATA_WRITE_CLK,
	output logic      [PTR_W-1:0]  FIFO_READ_PTR,
	output logic      [PTR_W-1:0]  FIFO_WRITE_PTR,
	output logic                   READ_WINDOW_VALID,
	output logic                   BURST_SEEN,
	output logic                   READ_TALLY,
	output logic                   WRITE_TALLY
);
	////////////////////////////////////////////////////////////////////////////
	logic        rst;
	logic        io_rst;
	logic [2:0]  fclk_s;
	logic [2:0]  strb_s;
	logic [1:0]  data_s;
	logic        fast_rise;
	logic        fast_fall;
	ddrgs_gear_t gear;
	logic [3:0]  bits;
	logic        bit_en;
	logic [3:0]  bcnt_q;
	logic        slow_en_q;
	logic        bit_last;

	assign rst    = !NRST;
	assign io_rst = !NRST || IO_RST;

	// Stage 0 feeds only stage 1; edges are taken from stages 1 and 2.
	always_ff @(posedge CLOCK) begin
		if (rst) begin
			fclk_s <= 3'h0;
			strb_s <= 3'h0;
			data_s <= 2'h0;
		end else begin
			fclk_s <= {fclk_s[1:0], FAST_EDGE_CLK};
			strb_s <= {strb_s[1:0], STROBE_IN};
			data_s <= {data_s[0], DATA_PIN};
		end
	end

	assign fast_rise = fclk_s[1] && !fclk_s[2];
	assign fast_fall = !fclk_s[1] && fclk_s[2];
	assign gear      = EDGE_IS_DDR ? ddrgs_decode(GEAR_SEL) : GEAR_SDR;
	assign bits      = ddrgs_bits(gear);
	assign bit_en    = (gear == GEAR_SDR) ? fast_rise : (fast_rise || fast_fall);
	assign bit_last  = bcnt_q >= bits - 4'h1;

	// Slow clock: one enable per complete word of fast edges.
	always_ff @(posedge CLOCK) begin
		if (io_rst) begin
			bcnt_q    <= 4'h0;
			slow_en_q <= 1'b0;
		end else begin
			slow_en_q <= bit_en && bit_last;
			if (bit_en) begin
				bcnt_q <= bit_last ? 4'h0 : bcnt_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	ddrgs_rx_gear u_rx (
		.clk    (CLOCK),
		.rst    (io_rst),
		.bit_en (bit_en),
		.din    (data_s[1]),
		.align  (WORD_ALIGN_REQ),
		.word_en(slow_en_q),
		.bits   (bits),
		.word   (RX_WORD)
	);

	////////////////////////////////////////////////////////////////////////////
	logic [RX_W-1:0] tx_sh_q;
	logic [RX_W-1:0] tx_src;
	logic [3:0]      tx_idx;

	assign tx_src = (bcnt_q == 4'h0) ? TX_WORD : tx_sh_q;
	assign tx_idx = (bcnt_q < bits) ? bits - 4'h1 - bcnt_q : 4'h0;

	always_ff @(posedge CLOCK) begin
		if (io_rst) begin
			tx_sh_q <= '0;
			TX_PIN  <= 1'b0;
		end else if (bit_en) begin
			if (gear == GEAR_SDR) begin
				TX_PIN <= TX_BIT;
			end else begin
				if (bcnt_q == 4'h0) begin
					tx_sh_q <= TX_WORD;
				end
				TX_PIN <= tx_src[tx_idx];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic       ts_ddr;
	logic [1:0] ts_q;

	assign ts_ddr = TRISTATE_DDR && EDGE_IS_DDR;

	always_ff @(posedge CLOCK) begin
		if (io_rst) begin
			ts_q              <= 2'h0;
			TRISTATE_CTRL_OUT <= 1'b0;
		end else if (!ts_ddr) begin
			if (slow_en_q) begin
				TRISTATE_CTRL_OUT <= TRISTATE_CTRL_IN[0];
			end
		end else begin
			if (slow_en_q) begin
				ts_q <= TRISTATE_CTRL_IN;
			end
			if (fast_rise) begin
				TRISTATE_CTRL_OUT <= ts_q[0];
			end else if (fast_fall) begin
				TRISTATE_CTRL_OUT <= ts_q[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// The edge clock is taken to match the memory clock; nothing here checks it.
	ddrgs_dly_if rd_if ();
	ddrgs_dly_if wr_if ();
	ddrgs_dly_if lv_if ();
	logic               rd_out;
	logic               wr_out;
	logic               lv_out;
	logic [QUARTER_CYC-2:0] dw_q;

	assign rd_if.load_n = READ_DELAY_LOAD_N;
	assign rd_if.step   = READ_DELAY_STEP;
	assign rd_if.dir    = READ_DELAY_DIR;
	assign rd_if.cal    = DELAY_CODE_IN;
	assign wr_if.load_n = WRITE_DELAY_LOAD_N;
	assign wr_if.step   = WRITE_DELAY_STEP;
	assign wr_if.dir    = WRITE_DELAY_DIR;
	assign wr_if.cal    = DELAY_CODE_IN;
	assign lv_if.load_n = WRITE_LEVEL_LOAD_N;
	assign lv_if.step   = WRITE_LEVEL_STEP;
	assign lv_if.dir    = WRITE_LEVEL_DIR;
	assign lv_if.cal    = CODE_RST;

	ddrgs_dly_line u_rd (.clk(CLOCK), .rst(rst), .din(strb_s[1]), .c(rd_if), .dout(rd_out));
	ddrgs_dly_line u_wr (.clk(CLOCK), .rst(rst), .din(fclk_s[1]), .c(wr_if), .dout(wr_out));
	ddrgs_dly_line u_lv (.clk(CLOCK), .rst(rst), .din(wr_out), .c(lv_if), .dout(lv_out));

	always_ff @(posedge CLOCK) begin
		if (rst) begin
			READ_CAPTURE_STROBE <= 1'b0;
			STROBE_WRITE_CLK    <= 1'b0;
			dw_q                <= '0;
			DATA_WRITE_CLK      <= 1'b0;
			DELAY_CODE_OUT      <= CODE_RST;
		end else begin
			READ_CAPTURE_STROBE <= rd_out;
			STROBE_WRITE_CLK    <= WRITE_LEVEL_EN ? lv_out : wr_out;
			dw_q                <= (QUARTER_CYC-1)'({dw_q, STROBE_WRITE_CLK});
			DATA_WRITE_CLK      <= dw_q[QUARTER_CYC-2];
			DELAY_CODE_OUT      <= rd_if.code;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One pointer pair serves every data lane of the sixteen-pin strobe group.
	logic rcs_q;
	logic strobe_rise;

	assign strobe_rise = READ_CAPTURE_STROBE && !rcs_q;

	always_ff @(posedge CLOCK) begin
		if (rst) begin
			rcs_q          <= 1'b0;
			FIFO_WRITE_PTR <= PTR_RST;
			FIFO_READ_PTR  <= PTR_RST;
			WRITE_TALLY    <= 1'b0;
			READ_TALLY     <= 1'b0;
		end else begin
			rcs_q       <= READ_CAPTURE_STROBE;
			WRITE_TALLY <= strobe_rise && FIFO_WRITE_PTR == PTR_LAST;
			READ_TALLY  <= 1'b0;
			if (strobe_rise) begin
				FIFO_WRITE_PTR <= FIFO_WRITE_PTR + 3'h1;
			end
			if (fast_rise && FIFO_READ_PTR != FIFO_WRITE_PTR) begin
				FIFO_READ_PTR <= FIFO_READ_PTR + 3'h1;
				READ_TALLY    <= FIFO_READ_PTR == PTR_LAST;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic       arm_q;
	logic [2:0] wait_q;
	logic [3:0] need_q;
	logic [3:0] win_q;
	logic [3:0] scnt_q;
	logic       req_go;
	logic       win_close;

	assign req_go    = slow_en_q && READ_REQ != 2'h0;
	assign win_close = fast_rise && win_q == 4'h1;

	always_ff @(posedge CLOCK) begin
		if (rst) begin
			arm_q  <= 1'b0;
			wait_q <= 3'h0;
			need_q <= 4'h0;
			win_q  <= 4'h0;
		end else if (req_go) begin
			arm_q  <= 1'b1;
			wait_q <= READ_PULSE_SEL;
			need_q <= ddrgs_burst(READ_REQ);
		end else if (fast_rise && arm_q) begin
			if (wait_q == 3'h0) begin
				arm_q <= 1'b0;
				win_q <= need_q;
			end else begin
				wait_q <= wait_q - 3'h1;
			end
		end else if (fast_rise && win_q != 4'h0) begin
			win_q <= win_q - 4'h1;
		end
	end

	// A burst that closes as a new request arrives still reports as seen.
	always_ff @(posedge CLOCK) begin
		if (rst) begin
			scnt_q            <= 4'h0;
			READ_WINDOW_VALID <= 1'b0;
			BURST_SEEN        <= 1'b0;
		end else begin
			READ_WINDOW_VALID <= win_q != 4'h0;
			if (req_go) begin
				scnt_q <= 4'h0;
			end else if (strobe_rise && win_q != 4'h0 && scnt_q != 4'hF) begin
				scnt_q <= scnt_q + 4'h1;
			end
			if (win_close && scnt_q >= need_q) begin
				BURST_SEEN <= 1'b1;
			end else if (req_go) begin
				BURST_SEEN <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_sdr_forced: assert property (@(posedge CLOCK) disable iff (rst)
		!EDGE_IS_DDR |-> bits == 4'h1)
		else $error("non-DDR edge used a geared ratio");
	a_tq_sdr: assert property (@(posedge CLOCK) disable iff (io_rst)
		slow_en_q && !ts_ddr |=> TRISTATE_CTRL_OUT == $past(TRISTATE_CTRL_IN[0]))
		else $error("SDR tristate flop did not capture");
	a_tq_ddr: assert property (@(posedge CLOCK) disable iff (io_rst)
		ts_ddr && fast_rise && !slow_en_q |=> TRISTATE_CTRL_OUT == $past(ts_q[0]))
		else $error("DDR tristate rising half wrong");
	a_tx_sdr: assert property (@(posedge CLOCK) disable iff (io_rst)
		gear == GEAR_SDR && bit_en |=> TX_PIN == $past(TX_BIT))
		else $error("SDR output bit not registered");
	a_wptr_step: assert property (@(posedge CLOCK) disable iff (rst)
		strobe_rise |=> FIFO_WRITE_PTR == $past(FIFO_WRITE_PTR) + 3'h1)
		else $error("write pointer missed a strobe");
	a_data_quarter: assert property (@(posedge CLOCK) disable iff (rst)
		##3 DATA_WRITE_CLK == $past(STROBE_WRITE_CLK, 2))
		else $error("data write clock not a quarter behind");
	a_code_report: assert property (@(posedge CLOCK) disable iff (rst)
		!READ_DELAY_LOAD_N ##1 !READ_DELAY_LOAD_N |=> DELAY_CODE_OUT == $past(DELAY_CODE_IN, 2))
		else $error("reported code does not follow the load");
	a_slow_word: assert property (@(posedge CLOCK) disable iff (io_rst)
		slow_en_q |-> bcnt_q == 4'h0 || $changed(bits))
		else $error("slow enable off the word boundary");
	a_io_reset: assert property (@(posedge CLOCK)
		io_rst |=> !TX_PIN && !TRISTATE_CTRL_OUT && RX_WORD == '0)
		else $error("core reset did not clear the I/O registers");
	a_valid_wait: assert property (@(posedge CLOCK) disable iff (rst)
		req_go && READ_PULSE_SEL == 3'h0 ##1 !READ_WINDOW_VALID |-> ##[1:40] READ_WINDOW_VALID)
		else $error("read window never opened");
	c_window: cover property (@(posedge CLOCK) disable iff (rst) $rose(READ_WINDOW_VALID));
	c_burst: cover property (@(posedge CLOCK) disable iff (rst) $rose(BURST_SEEN));
	c_wrap: cover property (@(posedge CLOCK) disable iff (rst) WRITE_TALLY);
endmodule : ddrgs_top

// [test_ddr_io_gearing_strobe_ctrl.sv]
// Purpose: Self-checking bench for the per-pin gearing and strobe control block.
// Assumes: Inputs change 5 ns after CLOCK rises; link clock comes from the model.
// Notes:   Word alignment is unknown after reset, so alternating patterns are used.
`timescale 1ns/100ps
module test_ddr_io_gearing_strobe_ctrl import ddrgs_pkg::*; ;
	logic              clk, nrst, io_rst, ddr, tri_ddr, tx_bit, align, sen;
	logic [2:0]        gear, psel;
	logic [1:0]        td, rreq;
	logic [9:0]        tx_word, pat;
	logic              rl_n, rs, rd, wl_n, ws, wd, le, ll_n, ls, ld;
	logic [CODE_W-1:0] code_in;
	logic              fast_edge_clk, din, strb;
	int                error_cnt, check_count;
	ddrgs_top ddrgs_top_i (.CLOCK(clk), .NRST(nrst), .IO_RST(io_rst), .EDGE_IS_DDR(ddr), .GEAR_SEL(gear),
		.FAST_EDGE_CLK(fast_edge_clk), .STROBE_IN(strb), .DATA_PIN(din), .WORD_ALIGN_REQ(align), .RX_WORD(),
		.TX_BIT(tx_bit), .TX_WORD(tx_word), .TX_PIN(), .TRISTATE_DDR(tri_ddr), .TRISTATE_CTRL_IN(td),
		.TRISTATE_CTRL_OUT(), .READ_REQ(rreq), .READ_PULSE_SEL(psel), .READ_DELAY_LOAD_N(rl_n),
		.READ_DELAY_STEP(rs), .READ_DELAY_DIR(rd), .WRITE_DELAY_LOAD_N(wl_n), .WRITE_DELAY_STEP(ws),
		.WRITE_DELAY_DIR(wd), .WRITE_LEVEL_EN(le), .WRITE_LEVEL_LOAD_N(ll_n), .WRITE_LEVEL_STEP(ls),
		.WRITE_LEVEL_DIR(ld), .DELAY_CODE_IN(code_in), .DELAY_CODE_OUT(), .READ_CAPTURE_STROBE(),
		.STROBE_WRITE_CLK(), .DATA_WRITE_CLK(), .FIFO_READ_PTR(), .FIFO_WRITE_PTR(),
		.READ_WINDOW_VALID(), .BURST_SEEN(), .READ_TALLY(), .WRITE_TALLY());
	ddrgs_link_model ddrgs_link_model_i (.strobe_en(sen), .pat(pat), .bits(4'h4), .edge_clk(fast_edge_clk),
		.data(din), .strobe(strb));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : cyc
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_sdr;
		ddr = 1'b0;
		gear = 3'h5;
		tx_bit = 1'b1;
		td = 2'h2;
		cyc(40);
		chk(16'(ddrgs_top_i.TX_PIN), 16'h1);
		chk(16'(ddrgs_top_i.TRISTATE_CTRL_OUT), 16'h0);
		td = 2'h1;
		cyc(40);
		chk(16'(ddrgs_top_i.TRISTATE_CTRL_OUT), 16'h1);
		io_rst = 1'b1;
		cyc(2);
		chk(16'({ddrgs_top_i.TX_PIN, ddrgs_top_i.TRISTATE_CTRL_OUT}), 16'h0);
		chk(16'(ddrgs_top_i.RX_WORD), 16'h0);
		io_rst = 1'b0;
		$display("sdr done");
	endtask : t_sdr
	task automatic t_rx;
		logic [9:0] w;
		ddr = 1'b1;
		gear = 3'h2;
		cyc(100);
		w = ddrgs_top_i.RX_WORD;
		chk(16'(w[9:4]), 16'h0);
		chk(16'(w[3:0] === 4'hA || w[3:0] === 4'h5), 16'h1);
		align = 1'b1;
		cyc(1);
		align = 1'b0;
		cyc(100);
		chk(16'(ddrgs_top_i.RX_WORD), (w[3:0] === 4'hA) ? 16'h5 : 16'hA);
		$display("rx done");
	endtask : t_rx
	task automatic t_tx;
		logic [7:0] s;
		for (int g = 1; g < 6; g++) begin
			gear = 3'(g);
			tx_word = 10'h3FF;
			cyc(80);
			chk(16'(ddrgs_top_i.TX_PIN), 16'h1);
		end
		gear = 3'h2;
		tx_word = 10'h00C;
		cyc(60);
		for (int i = 0; i < 8; i++) begin
			@(fast_edge_clk);
			#180;
			s = {s[6:0], ddrgs_top_i.TX_PIN};
		end
		chk(16'(s === 8'hCC || s === 8'h99 || s === 8'h33 || s === 8'h66), 16'h1);
		cyc(1);
		$display("tx done");
	endtask : t_tx
	task automatic t_tri;
		tri_ddr = 1'b1;
		td = 2'h1;
		cyc(60);
		@(posedge fast_edge_clk);
		#300;
		chk(16'(ddrgs_top_i.TRISTATE_CTRL_OUT), 16'h1);
		@(negedge fast_edge_clk);
		#300;
		chk(16'(ddrgs_top_i.TRISTATE_CTRL_OUT), 16'h0);
		cyc(1);
		$display("tri done");
	endtask : t_tri
	task automatic t_dly;
		code_in = 9'h0A5;
		rl_n = 1'b0;
		wl_n = 1'b0;
		ll_n = 1'b0;
		cyc(2);
		{rl_n, wl_n, ll_n} = 3'h7;
		cyc(3);
		chk(16'(ddrgs_top_i.DELAY_CODE_OUT), 16'h0A5);
		{rs, rd, ws, wd, ls, ld} = 6'h3F;
		cyc(1);
		{rs, ws, ls} = 3'h0;
		cyc(3);
		chk(16'(ddrgs_top_i.DELAY_CODE_OUT), 16'h0A6);
		chk(16'(ddrgs_top_i.wr_if.code), 16'h0A6);
		rd = 1'b0;
		rs = 1'b1;
		cyc(1);
		rs = 1'b0;
		cyc(3);
		chk(16'(ddrgs_top_i.DELAY_CODE_OUT), 16'h0A5);
		$display("delay done");
	endtask : t_dly
	task automatic t_read;
		logic [7:0] f;
		f = 8'h0;
		le = 1'b1;
		sen = 1'b1;
		psel = 3'h0;
		rreq = 2'h1;
		cyc(16);
		rreq = 2'h0;
		repeat (600) begin
			cyc(1);
			f = f | {ddrgs_top_i.READ_WINDOW_VALID, ddrgs_top_i.READ_CAPTURE_STROBE,
				ddrgs_top_i.STROBE_WRITE_CLK, ddrgs_top_i.DATA_WRITE_CLK, |ddrgs_top_i.FIFO_WRITE_PTR,
				|ddrgs_top_i.FIFO_READ_PTR, ddrgs_top_i.READ_TALLY, ddrgs_top_i.WRITE_TALLY};
		end
		chk(16'(f[7:6]), 16'h3);
		chk(16'(f[5:4]), 16'h3);
		chk(16'(f[3:2]), 16'h3);
		chk(16'(f[1:0]), 16'h3);
		chk(16'(ddrgs_top_i.BURST_SEEN), 16'h1);
		$display("read done");
	endtask : t_read
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#3_000_000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{nrst, io_rst, ddr, tri_ddr, tx_bit, align, sen} = 7'h0;
		{gear, psel, td, rreq} = 11'h0;
		{rs, rd, ws, wd, le, ls, ld} = 7'h0;
		{rl_n, wl_n, ll_n} = 3'h7;
		tx_word = 10'h000;
		pat = 10'h00A;
		code_in = 9'h000;
		error_cnt = 0;
		check_count = 0;
		cyc(20);
		chk(16'({ddrgs_top_i.RX_WORD, ddrgs_top_i.TX_PIN, ddrgs_top_i.FIFO_READ_PTR}), 16'h0);
		nrst = 1'b1;
		cyc(5);
		t_sdr();
		t_rx();
		t_tx();
		t_tri();
		t_dly();
		t_read();
		tally_and_finish();
	end
endmodule : test_ddr_io_gearing_strobe_ctrl
